// file: shared/rmp_defs.svh
/*
 * Constants of the reduced media-independent MAC port: link timing, frame
 * symbols, FIFO shape and the layout of a buffered word.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef RMP_DEFS_SVH
`define RMP_DEFS_SVH

// =====================================================================
// link timing
`define RMP_LINK_FREQ_MHZ 50
`define RMP_IFG_NS 960
// least gap, rounded up to whole link cycles
`define RMP_IFG_CYCLES (((`RMP_IFG_NS * `RMP_LINK_FREQ_MHZ) + 999) / 1000)

// =====================================================================
// frame symbols
`define RMP_PRE_BYTE 8'h55
`define RMP_SFD_BYTE 8'hD5
`define RMP_PRE_COUNT 6'h07
`define RMP_SFD_DIBIT 2'h3

// =====================================================================
// buffered word: {last, err, byte}
`define RMP_WORD_W 10
`define RMP_W_LAST 9
`define RMP_W_ERR 8
`define RMP_FIFO_DEPTH 8
`define RMP_FIFO_AW 3

`endif

// file: shared/rmp_pkg.sv
/*
 * Types of the reduced media-independent MAC port: state encodings.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rmp_pkg;

    // =================================================================
    // transmit state, one-hot
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_PRE = 4'h2,
        TX_DATA = 4'h4,
        TX_GAP = 4'h8
    } rmp_tx_state_t;

    // =================================================================
    // receive state, one-hot
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_HUNT = 4'h2,
        RX_DATA = 4'h4,
        RX_FLUSH = 4'h8
    } rmp_rx_state_t;

endpackage : rmp_pkg

`default_nettype wire

// file: shared/rmp_stream_if.sv
/*
 * Valid/ready stream carrier between the port and its FIFOs.
 * Assumes a producer on modport src and a consumer on modport snk.
 */
`timescale 1ns/100ps
`default_nettype none

interface rmp_stream_if #(parameter int WIDTH = 10);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rmp_stream_if

`default_nettype wire

// file: logic/rmp_sync.sv
/*
 * Two-flop synchroniser for a vector of independent levels or gray codes.
 * Assumes the destination clock and its own reset.
 */
`timescale 1ns/100ps
`default_nettype none

module rmp_sync #(parameter int WIDTH = 1) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] hold_r;

    // =================================================================
    // two stages; the first is read by the second only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            hold_r <= '0;
        end else begin
            meta_r <= d;
            hold_r <= meta_r;
        end
    end

    assign q = hold_r;
endmodule : rmp_sync

`default_nettype wire

// file: logic/rmp_fifo.sv
/*
 * Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
 * Assumes DEPTH equals 2**AW and AW of at least 2.
 */
`timescale 1ns/100ps
`default_nettype none

module rmp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic wr_clk,
    input wire logic wr_rstn,
    input wire logic rd_clk,
    input wire logic rd_rstn,
    rmp_stream_if.snk wr,
    rmp_stream_if.src rd
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin_r;
    logic [AW:0] wbin_nxt;
    logic [AW:0] wgray_r;
    logic [AW:0] rbin_r;
    logic [AW:0] rbin_nxt;
    logic [AW:0] rgray_r;
    logic [AW:0] rgray_s;
    logic [AW:0] wgray_s;
    logic full;
    logic empty;
    logic push;
    logic pop;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    // =================================================================
    // pointer crossings
    rmp_sync #(.WIDTH(AW + 1)) u_r2w (
        .clk(wr_clk),
        .rstn(wr_rstn),
        .d(rgray_r),
        .q(rgray_s)
    );
    rmp_sync #(.WIDTH(AW + 1)) u_w2r (
        .clk(rd_clk),
        .rstn(rd_rstn),
        .d(wgray_r),
        .q(wgray_s)
    );

    // =================================================================
    // flags and handshakes
    assign full = (wgray_r == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
    assign empty = (rgray_r == wgray_s);
    assign push = wr.valid && !full;
    assign pop = rd.ready && !empty;
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rbin_r[AW-1:0]];

    // next pointer values
    always_comb begin
        wbin_nxt = wbin_r + {{AW{1'b0}}, push};
        rbin_nxt = rbin_r + {{AW{1'b0}}, pop};
    end

    // write side
    always_ff @(posedge wr_clk or negedge wr_rstn) begin
        if (!wr_rstn) begin
            wbin_r <= '0;
            wgray_r <= '0;
        end else begin
            wbin_r <= wbin_nxt;
            wgray_r <= to_gray(wbin_nxt);
        end
    end

    // storage, no reset needed
    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem[wbin_r[AW-1:0]] <= wr.data;
        end
    end

    // read side
    always_ff @(posedge rd_clk or negedge rd_rstn) begin
        if (!rd_rstn) begin
            rbin_r <= '0;
            rgray_r <= '0;
        end else begin
            rbin_r <= rbin_nxt;
            rgray_r <= to_gray(rbin_nxt);
        end
    end
endmodule : rmp_fifo

`default_nettype wire

// file: logic/rmp_mac_port.sv
/*
 * Reduced media-independent port of an Ethernet MAC: di-bit transmit and
 * receive on the link clock, byte streams on the system clock, one FIFO
 * per direction to cross between them.
 * Assumes a free-running 50 MHz link clock from the board and a PHY that
 * drives receive data and error on that clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rmp_defs.svh"

module rmp_mac_port (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic link_clk,
    output logic ref_clk_out,
    output logic tx_en_out,
    output logic [1:0] txd_out,
    input wire logic carrier_rx_valid,
    input wire logic rx_error_in,
    input wire logic [1:0] rxd_in,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_err,
    output logic rx_valid,
    input wire logic rx_ready
);
    // =================================================================
    // declarations
    logic lrst_meta_r;
    logic lrst_r;
    logic link_rstn;
    logic [3:0] pins_s;
    logic crs_s;
    logic rx_er_s;
    logic [1:0] rxd_s;

    rmp_pkg::rmp_tx_state_t tx_state_r;
    rmp_pkg::rmp_tx_state_t tx_state_nxt;
    logic [7:0] tx_shift_r;
    logic [7:0] tx_shift_nxt;
    logic [1:0] tx_dib_r;
    logic [1:0] tx_dib_nxt;
    logic [5:0] tx_cnt_r;
    logic [5:0] tx_cnt_nxt;
    logic tx_last_r;
    logic tx_last_nxt;
    logic tx_en_r;
    logic tx_en_nxt;
    logic [1:0] txd_r;
    logic [1:0] txd_nxt;
    logic tx_pop;

    rmp_pkg::rmp_rx_state_t rx_state_r;
    rmp_pkg::rmp_rx_state_t rx_state_nxt;
    logic [7:0] rx_shift_r;
    logic [7:0] rx_shift_nxt;
    logic [1:0] rx_dib_r;
    logic [1:0] rx_dib_nxt;
    logic rx_err_r;
    logic rx_err_nxt;
    logic [7:0] rx_pend_r;
    logic [7:0] rx_pend_nxt;
    logic rx_pend_v_r;
    logic rx_pend_v_nxt;
    logic rx_push;
    logic [`RMP_WORD_W-1:0] rx_word;

    rmp_stream_if #(.WIDTH(`RMP_WORD_W)) txq_in ();
    rmp_stream_if #(.WIDTH(`RMP_WORD_W)) txq_out ();
    rmp_stream_if #(.WIDTH(`RMP_WORD_W)) rxq_in ();
    rmp_stream_if #(.WIDTH(`RMP_WORD_W)) rxq_out ();

    // =================================================================
    // clock forwarding and link-side reset
    assign ref_clk_out = link_clk;

    // release the link-side reset on the link clock
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_meta_r <= 1'b0;
            lrst_r <= 1'b0;
        end else begin
            lrst_meta_r <= 1'b1;
            lrst_r <= lrst_meta_r;
        end
    end
    assign link_rstn = lrst_r;

    // =================================================================
    // receive pin capture, all delayed alike so they stay aligned
    rmp_sync #(.WIDTH(4)) u_rx_pins (
        .clk(link_clk),
        .rstn(link_rstn),
        .d({carrier_rx_valid, rx_error_in, rxd_in}),
        .q(pins_s)
    );
    assign crs_s = pins_s[3];
    assign rx_er_s = pins_s[2];
    assign rxd_s = pins_s[1:0];

    // =================================================================
    // FIFOs between the system clock and the link clock
    rmp_fifo #(.WIDTH(`RMP_WORD_W), .DEPTH(`RMP_FIFO_DEPTH), .AW(`RMP_FIFO_AW)) u_tx_fifo (
        .wr_clk(ref_clk),
        .wr_rstn(rstn),
        .rd_clk(link_clk),
        .rd_rstn(link_rstn),
        .wr(txq_in),
        .rd(txq_out)
    );
    rmp_fifo #(.WIDTH(`RMP_WORD_W), .DEPTH(`RMP_FIFO_DEPTH), .AW(`RMP_FIFO_AW)) u_rx_fifo (
        .wr_clk(link_clk),
        .wr_rstn(link_rstn),
        .rd_clk(ref_clk),
        .rd_rstn(rstn),
        .wr(rxq_in),
        .rd(rxq_out)
    );

    // system-side streams
    assign txq_in.valid = tx_valid;
    assign txq_in.data = {tx_last, 1'b0, tx_data};
    assign tx_ready = txq_in.ready;
    assign rx_valid = rxq_out.valid;
    assign rx_data = rxq_out.data[7:0];
    assign rx_last = rxq_out.data[`RMP_W_LAST];
    assign rx_err = rxq_out.data[`RMP_W_ERR];
    assign rxq_out.ready = rx_ready;

    // link-side handshakes
    assign txq_out.ready = tx_pop;
    assign rxq_in.valid = rx_push;
    assign rxq_in.data = rx_word;

    // =================================================================
    // transmit: preamble, start delimiter, bytes low di-bit first, gap
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_shift_nxt = tx_shift_r;
        tx_dib_nxt = tx_dib_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_last_nxt = tx_last_r;
        tx_en_nxt = 1'b0;
        txd_nxt = 2'h0;
        tx_pop = 1'b0;
        case (tx_state_r)
            rmp_pkg::TX_IDLE: begin
                if (txq_out.valid) begin
                    tx_state_nxt = rmp_pkg::TX_PRE;
                    tx_shift_nxt = `RMP_PRE_BYTE;
                    tx_dib_nxt = 2'h0;
                    tx_cnt_nxt = 6'h00;
                    tx_last_nxt = 1'b0;
                end
            end
            rmp_pkg::TX_PRE, rmp_pkg::TX_DATA: begin
                tx_en_nxt = 1'b1;
                txd_nxt = tx_shift_r[1:0];
                tx_shift_nxt = {2'h0, tx_shift_r[7:2]};
                tx_dib_nxt = tx_dib_r + 2'h1;
                if (tx_dib_r == 2'h3) begin
                    if (tx_state_r == rmp_pkg::TX_PRE && tx_cnt_r != `RMP_PRE_COUNT) begin
                        tx_cnt_nxt = tx_cnt_r + 6'h01;
                        if (tx_cnt_r == `RMP_PRE_COUNT - 6'h01) begin
                            tx_shift_nxt = `RMP_SFD_BYTE;
                        end else begin
                            tx_shift_nxt = `RMP_PRE_BYTE;
                        end
                    end else if (tx_state_r == rmp_pkg::TX_DATA && tx_last_r) begin
                        tx_state_nxt = rmp_pkg::TX_GAP;
                        tx_cnt_nxt = 6'h00;
                    end else if (txq_out.valid) begin
                        tx_pop = 1'b1;
                        tx_shift_nxt = txq_out.data[7:0];
                        tx_last_nxt = txq_out.data[`RMP_W_LAST];
                        tx_state_nxt = rmp_pkg::TX_DATA;
                    end else begin
                        // underrun: frame is cut short after this byte
                        tx_state_nxt = rmp_pkg::TX_GAP;
                        tx_cnt_nxt = 6'h00;
                    end
                end
            end
            rmp_pkg::TX_GAP: begin
                tx_cnt_nxt = tx_cnt_r + 6'h01;
                if (tx_cnt_r == 6'(`RMP_IFG_CYCLES - 1)) begin
                    tx_state_nxt = rmp_pkg::TX_IDLE;
                end
            end
            default: begin
                tx_state_nxt = rmp_pkg::TX_IDLE;
            end
        endcase
    end

    // transmit registers, outputs straight from flops
    always_ff @(posedge link_clk or negedge link_rstn) begin
        if (!link_rstn) begin
            tx_state_r <= rmp_pkg::TX_IDLE;
            tx_shift_r <= 8'h00;
            tx_dib_r <= 2'h0;
            tx_cnt_r <= 6'h00;
            tx_last_r <= 1'b0;
            tx_en_r <= 1'b0;
            txd_r <= 2'h0;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_dib_r <= tx_dib_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_last_r <= tx_last_nxt;
            tx_en_r <= tx_en_nxt;
            txd_r <= txd_nxt;
        end
    end
    assign tx_en_out = tx_en_r;
    assign txd_out = txd_r;

    // =================================================================
    // receive: hunt for the delimiter, gather bytes, hold one back to
    // tag the last byte when carrier drops
    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_shift_nxt = rx_shift_r;
        rx_dib_nxt = rx_dib_r;
        rx_err_nxt = rx_err_r;
        rx_pend_nxt = rx_pend_r;
        rx_pend_v_nxt = rx_pend_v_r;
        rx_push = 1'b0;
        rx_word = {1'b0, rx_err_r, rx_pend_r};
        case (rx_state_r)
            rmp_pkg::RX_IDLE: begin
                if (crs_s) begin
                    rx_state_nxt = rmp_pkg::RX_HUNT;
                    rx_err_nxt = rx_er_s;
                    rx_pend_v_nxt = 1'b0;
                end
            end
            rmp_pkg::RX_HUNT: begin
                if (!crs_s) begin
                    // false carrier or runt: nothing is delivered
                    rx_state_nxt = rmp_pkg::RX_IDLE;
                end else begin
                    rx_err_nxt = rx_err_r | rx_er_s;
                    if (rxd_s == `RMP_SFD_DIBIT) begin
                        rx_state_nxt = rmp_pkg::RX_DATA;
                        rx_dib_nxt = 2'h0;
                    end
                end
            end
            rmp_pkg::RX_DATA: begin
                if (crs_s) begin
                    rx_shift_nxt = {rxd_s, rx_shift_r[7:2]};
                    rx_dib_nxt = rx_dib_r + 2'h1;
                    if (rx_dib_r == 2'h3) begin
                        rx_push = rx_pend_v_r;
                        rx_pend_nxt = rx_shift_nxt;
                        rx_pend_v_nxt = 1'b1;
                    end
                    // a byte refused by a full FIFO spoils the frame
                    rx_err_nxt = rx_err_r | rx_er_s | (rx_push & ~rxq_in.ready);
                end else if (rx_pend_v_r) begin
                    rx_push = 1'b1;
                    rx_word = {1'b1, rx_err_r | (rx_dib_r != 2'h0), rx_pend_r};
                    rx_err_nxt = rx_err_r | (rx_dib_r != 2'h0);
                    rx_state_nxt = rxq_in.ready ? rmp_pkg::RX_IDLE : rmp_pkg::RX_FLUSH;
                end else begin
                    rx_state_nxt = rmp_pkg::RX_IDLE;
                end
            end
            rmp_pkg::RX_FLUSH: begin
                // the closing word waits for room so frames never merge
                rx_push = 1'b1;
                rx_word = {1'b1, rx_err_r, rx_pend_r};
                if (rxq_in.ready) begin
                    rx_state_nxt = rmp_pkg::RX_IDLE;
                end
            end
            default: begin
                rx_state_nxt = rmp_pkg::RX_IDLE;
            end
        endcase
    end

    // receive registers
    always_ff @(posedge link_clk or negedge link_rstn) begin
        if (!link_rstn) begin
            rx_state_r <= rmp_pkg::RX_IDLE;
            rx_shift_r <= 8'h00;
            rx_dib_r <= 2'h0;
            rx_err_r <= 1'b0;
            rx_pend_r <= 8'h00;
            rx_pend_v_r <= 1'b0;
        end else begin
            rx_state_r <= rx_state_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_dib_r <= rx_dib_nxt;
            rx_err_r <= rx_err_nxt;
            rx_pend_r <= rx_pend_nxt;
            rx_pend_v_r <= rx_pend_v_nxt;
        end
    end
endmodule : rmp_mac_port

`default_nettype wire

// file: verif/rmp_port_props.sv
/*
 * Checker of the MAC port pins and streams.
 * Assumes binding onto rmp_mac_port; link clock never shares an edge with ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module rmp_port_props (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic ref_clk_out,
    input wire logic tx_en_out,
    input wire logic [1:0] txd_out,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_err,
    input wire logic rx_valid,
    input wire logic rx_ready
);
    logic [7:0] run_r, run_nxt;
    logic [6:0] gap_r, gap_nxt;

    // =====
    // helpers: cycles of the enable run, low cycles since it ended
    always_comb begin
        run_nxt = tx_en_out ? run_r + 8'h01 : 8'h00;
        gap_nxt = tx_en_out ? 7'h00 : ((gap_r == 7'h7F) ? gap_r : gap_r + 7'h01);
    end

    // registers of the helpers
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            run_r <= 8'h00;
            gap_r <= 7'h7F;
        end else begin
            run_r <= run_nxt;
            gap_r <= gap_nxt;
        end
    end

    // =====
    // sequences
    sequence s_tx_start;
        $rose(tx_en_out) ##0 txd_out == 2'h1;
    endsequence

    // =====
    // assertions
    a_clk_out_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
        ref_clk_out == link_clk) else $error("clock out differs from link clock");
    a_pre_first: assert property (@(posedge link_clk) disable iff (!rstn)
        $rose(tx_en_out) |-> txd_out == 2'h1) else $error("first di-bit not preamble");
    a_pre_run: assert property (@(posedge link_clk) disable iff (!rstn)
        s_tx_start |=> (tx_en_out && txd_out == 2'h1) [*8]) else $error("preamble broken");
    a_pre_body: assert property (@(posedge link_clk) disable iff (!rstn)
        tx_en_out && run_r < 8'h1F |-> txd_out == 2'h1) else $error("preamble di-bit wrong");
    a_sfd_end: assert property (@(posedge link_clk) disable iff (!rstn)
        tx_en_out && run_r == 8'h1F |-> txd_out == 2'h3) else $error("delimiter end wrong");
    a_whole_bytes: assert property (@(posedge link_clk) disable iff (!rstn)
        $fell(tx_en_out) |-> run_r >= 8'h24 && run_r[1:0] == 2'h0) else $error("frame cut");
    a_frame_gap: assert property (@(posedge link_clk) disable iff (!rstn)
        $rose(tx_en_out) |-> gap_r >= 7'h30) else $error("gap too short");
    a_rx_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_valid && !rx_ready |=> rx_valid && $stable({rx_data, rx_last, rx_err}))
        else $error("receive word changed while held");
    a_full_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(tx_ready) |-> $past(tx_valid)) else $error("full without write");
endmodule : rmp_port_props

bind rmp_mac_port rmp_port_props u_props (.ref_clk(ref_clk), .rstn(rstn),
    .link_clk(link_clk), .ref_clk_out(ref_clk_out), .tx_en_out(tx_en_out),
    .txd_out(txd_out), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_last(rx_last), .rx_err(rx_err), .rx_valid(rx_valid), .rx_ready(rx_ready));

`default_nettype wire

// file: verif/rmp_phy_model.sv
/*
 * Behavioural PHY: rebuilds transmitted bytes, sends receive frames.
 * Assumes the port's link clock; bench fills pay before calling send.
 */
`timescale 1ns/100ps
`default_nettype none

module rmp_phy_model (
    input wire logic link_clk,
    input wire logic tx_en_out,
    input wire logic [1:0] txd_out,
    output var logic carrier_rx_valid,
    output var logic rx_error_in,
    output var logic [1:0] rxd_in
);
    logic [7:0] pay [0:15];
    logic [7:0] cap_q [$];
    logic [3:0] dq [$];
    logic [7:0] sh = 8'h00;
    int pre_cnt = 0;
    int last_pre = 0;
    int nib = 0;
    bit sfd_seen = 1'b0;
    int cut = 0;

    // =====
    // transmit capture, di-bits lsb first, bit 1 more significant
    always @(posedge link_clk) begin
        if (!tx_en_out) begin
            sfd_seen = 1'b0;
            pre_cnt = 0;
            nib = 0;
        end else if (!sfd_seen) begin
            if (txd_out == 2'h3) begin
                sfd_seen = 1'b1;
                last_pre = pre_cnt;
            end else
                pre_cnt++;
        end else begin
            sh = {txd_out, sh[7:2]};
            nib++;
            if (nib == 4) begin
                cap_q.push_back(sh);
                nib = 0;
            end
        end
    end

    // receive pins: queued di-bits, else idle with changing data
    always @(posedge link_clk) begin
        if (dq.size() != 0) begin
            {carrier_rx_valid, rx_error_in, rxd_in} <= dq.pop_front();
        end else begin
            carrier_rx_valid <= 1'b0;
            rx_error_in <= 1'b0;
            rxd_in <= rxd_in + 2'h1;
        end
    end

    initial begin
        carrier_rx_valid = 1'b0;
        rx_error_in = 1'b0;
        rxd_in = 2'h0;
    end

    // preamble, delimiter (or none for a false carrier), n bytes; error at one di-bit;
    // cut drops that many trailing di-bits so carrier ends mid-byte, then clears itself
    task automatic send(input int n, input int err_at, input bit sfd);
        logic [7:0] b;
        for (int i = 0; i < 8 + n; i++) begin
            b = (i < 7 || !sfd) ? 8'h55 : ((i == 7) ? 8'hD5 : pay[i - 8]);
            for (int k = 0; k < 4; k++)
                dq.push_back({1'b1, (i * 4 + k) == err_at, b[2 * k +: 2]});
        end
        repeat (cut)
            void'(dq.pop_back());
        cut = 0;
        while (dq.size() != 0)
            @(posedge link_clk);
    endtask : send
endmodule : rmp_phy_model

`default_nettype wire

// file: verif/test_rmii_mac_port.sv
/*
 * Self-checking bench of the MAC port: both directions through the PHY model.
 * Assumes design, package, interface, checker and PHY model compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module test_rmii_mac_port;
    logic ref_clk, link_clk, ref_clk_out, tx_en_out, carrier_rx_valid, rx_error_in;
    logic tx_ready, rx_last, rx_err, rx_valid;
    logic rstn = 1'b0;
    logic tx_last = 1'b0;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic stall = 1'b0;
    logic saw_full = 1'b0;
    logic [1:0] txd_out, rxd_in;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data;
    logic [31:0] seed = 32'h340C7270;
    logic [9:0] got_q [$];
    logic [7:0] exp_q [$];
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;

    rmp_mac_port uut (.ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk),
        .ref_clk_out(ref_clk_out), .tx_en_out(tx_en_out), .txd_out(txd_out),
        .carrier_rx_valid(carrier_rx_valid), .rx_error_in(rx_error_in), .rxd_in(rxd_in),
        .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_last(rx_last), .rx_err(rx_err), .rx_valid(rx_valid),
        .rx_ready(rx_ready));
    rmp_phy_model phy (.link_clk(link_clk), .tx_en_out(tx_en_out), .txd_out(txd_out),
        .carrier_rx_valid(carrier_rx_valid), .rx_error_in(rx_error_in), .rxd_in(rxd_in));

    // =====
    // clocks: 100 MHz system, 80 ns link offset off the system edges
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #40 link_clk = ~link_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expd);
        tests_run++;
        if (seen !== expd) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, expd, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // random consumer stalls, receive collector, hang limit
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        seed <= xs(seed);
        rx_ready <= !stall && (seed[2:0] != 3'h0);
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            got_q.push_back({rx_last, rx_err, rx_data});
        if (cycles == 60000) begin
            fail_count++;
            summarize();
        end
    end

    // one frame of n random bytes, held until taken
    task automatic tx_frame(input int n);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = seed[7:0] ^ 8'(i);
            exp_q.push_back(b);
            tx_data <= b;
            tx_last <= (i == n - 1);
            tx_valid <= 1'b1;
            @(negedge ref_clk);
            while (tx_ready !== 1'b1) begin
                saw_full = 1'b1;
                @(negedge ref_clk);
            end
            @(posedge ref_clk);
        end
    endtask : tx_frame

    // one receive frame; model keeps 8 words, drops the rest bar the last when stalled;
    // a last byte cut short by the PHY is lost and spoils the frame
    task automatic rx_case(input int n, input int err_at, input bit sfd, input bit st);
        logic [9:0] w;
        got_q.delete();
        exp_q.delete();
        stall <= st;
        for (int i = 0; i < n; i++) begin
            phy.pay[i] = seed[7:0] + 8'(i * 37);
            if ((!st || i < 8 || i == n - 1) && !(i == n - 1 && phy.cut > 0))
                exp_q.push_back(phy.pay[i]);
        end
        phy.send(n, err_at, sfd);
        stall <= 1'b0;
        for (int m = 0; m < 800 && got_q.size() < exp_q.size(); m++)
            @(posedge ref_clk);
        repeat (100) @(posedge ref_clk);
        chk("rx words", got_q.size(), exp_q.size());
        foreach (got_q[i]) begin
            w = got_q[i];
            chk("rx byte", w[7:0], exp_q[i]);
            chk("rx last", w[9], i == got_q.size() - 1);
            if (i == got_q.size() - 1)
                chk("rx err", w[8], err_at >= 0 || exp_q.size() < n);
        end
        $display("rx case done n=%0d err_at=%0d", n, err_at);
    endtask : rx_case

    // =====
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        chk("tx_en in reset", tx_en_out, 1'b0);
        chk("rx_valid in reset", rx_valid, 1'b0);
        chk("tx_ready in reset", tx_ready, 1'b1);
        rstn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        tx_frame(12);
        tx_frame(3);
        tx_valid <= 1'b0;
        for (int m = 0; m < 5000 && phy.cap_q.size() < 15; m++)
            @(posedge ref_clk);
        chk("tx bytes", phy.cap_q.size(), 15);
        foreach (exp_q[i])
            chk("tx byte", phy.cap_q[i], exp_q[i]);
        chk("preamble di-bits", phy.last_pre, 31);
        chk("tx fifo refused", saw_full, 1'b1);
        chk("noise words", got_q.size(), 0);
        $display("tx test done");
        rx_case(6, -1, 1'b1, 1'b0);
        rx_case(4, 40, 1'b1, 1'b0);
        rx_case(0, -1, 1'b0, 1'b0);
        rx_case(10, -1, 1'b1, 1'b1);
        rx_case(1, -1, 1'b1, 1'b0);
        phy.cut = 2;
        rx_case(3, -1, 1'b1, 1'b0);
        summarize();
    end
endmodule : test_rmii_mac_port

`default_nettype wire
